// ==== offset_corr_top.sv ====
// offset correction loop with its mode registers behind an AXI4-Lite slave
// assumes REF_CLK is the 100 MHz sample clock and the AXI master shares it
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module offset_corr_top (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // AXI4-Lite write address
    input wire logic [offset_corr_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [offset_corr_pkg::AXI_DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [offset_corr_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [offset_corr_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // sample path
    input wire logic [offset_corr_pkg::SAMPLE_W-1:0] SAMPLE_IN,
    output logic [offset_corr_pkg::SAMPLE_W-1:0] SAMPLE_OUT,
    // mode outputs to the analog side
    output logic HIGH_FREQ_MODE,
    output logic LOW_SPEED_MODE,
    output logic CORR_ACTIVE
);
    import offset_corr_pkg::*;

    typedef enum logic [1:0] {
        W_IDLE = 2'b01,
        W_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        R_IDLE = 2'b01,
        R_DATA = 2'b10
    } rd_state_t;

    // write channel state
    wr_state_t wr_state_r;
    wr_state_t wr_state_nxt;
    logic aw_got_r;
    logic aw_got_nxt;
    logic w_got_r;
    logic w_got_nxt;
    logic [IDX_W-1:0] aw_idx_r;
    logic [IDX_W-1:0] aw_idx_nxt;
    logic [7:0] w_byte_r;
    logic [7:0] w_byte_nxt;
    logic w_lane_r;
    logic w_lane_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic wr_fire;

    // read channel state
    rd_state_t rd_state_r;
    rd_state_t rd_state_nxt;
    logic [AXI_DATA_W-1:0] rdata_r;
    logic [AXI_DATA_W-1:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // register file
    logic fmt_en_r;
    logic fmt_en_nxt;
    logic dig_en_r;
    logic dig_en_nxt;
    logic hold_r;
    logic hold_nxt;
    logic [3:0] span_r;
    logic [3:0] span_nxt;
    logic hf_r;
    logic hf_nxt;
    logic [3:0] ped_r;
    logic [3:0] ped_nxt;
    logic [1:0] speed_r;
    logic [1:0] speed_nxt;

    // sample path
    loop_cfg_t cfg;
    logic active;
    logic signed [ERR_W-1:0] estimate;

    // index decode for the write response; the read channel decodes indices in its own case
    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx, input logic wr);
        unique case (idx)
            IDX_FORMAT_CTRL, IDX_DIGITAL_MODE, IDX_LOOP_CTRL,
            IDX_HF_TUNING, IDX_TARGET_SHIFT, IDX_SPEED_SEL: idx_mapped = 1'b1;
            IDX_EST_STATUS: idx_mapped = !wr;
            default: idx_mapped = 1'b0;
        endcase
    endfunction

    // write channel: address and data taken in either order, response after both
    assign S_AXI_AWREADY = (wr_state_r == W_IDLE) && !aw_got_r;
    assign S_AXI_WREADY = (wr_state_r == W_IDLE) && !w_got_r;

    always_comb begin
        wr_state_nxt = wr_state_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        aw_idx_nxt = aw_idx_r;
        w_byte_nxt = w_byte_r;
        w_lane_nxt = w_lane_r;
        bresp_nxt = bresp_r;
        wr_fire = 1'b0;
        unique case (wr_state_r)
            W_IDLE: begin
                if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                    aw_got_nxt = 1'b1;
                    aw_idx_nxt = S_AXI_AWADDR[IDX_LSB +: IDX_W];
                end
                if (S_AXI_WVALID && S_AXI_WREADY) begin
                    w_got_nxt = 1'b1;
                    w_byte_nxt = S_AXI_WDATA[7:0];
                    w_lane_nxt = S_AXI_WSTRB[0];
                end
                if (aw_got_r && w_got_r) begin
                    wr_fire = 1'b1;
                    aw_got_nxt = 1'b0;
                    w_got_nxt = 1'b0;
                    bresp_nxt = idx_mapped(aw_idx_r, 1'b1) ? RESP_OKAY : RESP_SLVERR;
                    wr_state_nxt = W_RESP;
                end
            end
            W_RESP: begin
                if (S_AXI_BREADY) begin
                    wr_state_nxt = W_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wr_state_r <= W_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_idx_r <= '0;
            w_byte_r <= '0;
            w_lane_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            aw_idx_r <= aw_idx_nxt;
            w_byte_r <= w_byte_nxt;
            w_lane_r <= w_lane_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    assign S_AXI_BVALID = (wr_state_r == W_RESP);
    assign S_AXI_BRESP = bresp_r;

    // register file; only byte lane 0 carries register bits
    // reserved bits are not stored, so software writing them nonzero is harmless
    always_comb begin
        fmt_en_nxt = fmt_en_r;
        dig_en_nxt = dig_en_r;
        hold_nxt = hold_r;
        span_nxt = span_r;
        hf_nxt = hf_r;
        ped_nxt = ped_r;
        speed_nxt = speed_r;
        if (wr_fire && w_lane_r) begin
            unique case (aw_idx_r)
                IDX_FORMAT_CTRL: fmt_en_nxt = w_byte_r[FMT_EN_BIT];
                IDX_DIGITAL_MODE: dig_en_nxt = w_byte_r[DIG_EN_BIT];
                IDX_LOOP_CTRL: begin
                    hold_nxt = w_byte_r[HOLD_BIT];
                    span_nxt = w_byte_r[SPAN_MSB:SPAN_LSB];
                end
                IDX_HF_TUNING: hf_nxt = w_byte_r[HF_BIT];
                IDX_TARGET_SHIFT: ped_nxt = w_byte_r[PED_MSB:PED_LSB];
                IDX_SPEED_SEL: speed_nxt = w_byte_r[SPEED_MSB:SPEED_LSB];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fmt_en_r <= REG_RESET[FMT_EN_BIT];
            dig_en_r <= REG_RESET[DIG_EN_BIT];
            hold_r <= REG_RESET[HOLD_BIT];
            span_r <= REG_RESET[SPAN_MSB:SPAN_LSB];
            hf_r <= REG_RESET[HF_BIT];
            ped_r <= REG_RESET[PED_MSB:PED_LSB];
            speed_r <= REG_RESET[SPEED_MSB:SPEED_LSB];
        end else begin
            fmt_en_r <= fmt_en_nxt;
            dig_en_r <= dig_en_nxt;
            hold_r <= hold_nxt;
            span_r <= span_nxt;
            hf_r <= hf_nxt;
            ped_r <= ped_nxt;
            speed_r <= speed_nxt;
        end
    end

    // read channel: one read at a time, data registered
    assign S_AXI_ARREADY = (rd_state_r == R_IDLE);

    always_comb begin
        rd_state_nxt = rd_state_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        unique case (rd_state_r)
            R_IDLE: begin
                if (S_AXI_ARVALID) begin
                    rdata_nxt = '0;
                    rresp_nxt = RESP_OKAY;
                    unique case (S_AXI_ARADDR[IDX_LSB +: IDX_W])
                        IDX_FORMAT_CTRL: rdata_nxt[FMT_EN_BIT] = fmt_en_r;
                        IDX_DIGITAL_MODE: rdata_nxt[DIG_EN_BIT] = dig_en_r;
                        IDX_LOOP_CTRL: begin
                            rdata_nxt[HOLD_BIT] = hold_r;
                            rdata_nxt[SPAN_MSB:SPAN_LSB] = span_r;
                        end
                        IDX_HF_TUNING: rdata_nxt[HF_BIT] = hf_r;
                        IDX_TARGET_SHIFT: rdata_nxt[PED_MSB:PED_LSB] = ped_r;
                        IDX_SPEED_SEL: rdata_nxt[SPEED_MSB:SPEED_LSB] = speed_r;
                        IDX_EST_STATUS: begin
                            // live estimate, sign-extended, with loop state on top
                            rdata_nxt[ERR_W-1:0] = estimate;
                            rdata_nxt[STAT_HOLD_BIT-1:ERR_W] =
                                {(STAT_HOLD_BIT-ERR_W){estimate[ERR_W-1]}};
                            rdata_nxt[STAT_HOLD_BIT] = active && hold_r;
                            rdata_nxt[STAT_ACTIVE_BIT] = active;
                        end
                        default: rresp_nxt = RESP_SLVERR;
                    endcase
                    rd_state_nxt = R_DATA;
                end
            end
            R_DATA: begin
                if (S_AXI_RREADY) begin
                    rd_state_nxt = R_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rd_state_r <= R_IDLE;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign S_AXI_RVALID = (rd_state_r == R_DATA);
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    // correction runs only with the enable set and low latency turned off
    assign active = fmt_en_r && dig_en_r;

    always_comb begin
        cfg.enable = active;
        cfg.hold = hold_r;
        cfg.span = span_r;
        cfg.pedestal = $signed(ped_r);
    end

    offset_estimator u_est (
        .clk(REF_CLK),
        .rst_n(NRST),
        .cfg(cfg),
        .sample(SAMPLE_IN),
        .estimate(estimate)
    );

    sample_corrector u_corr (
        .clk(REF_CLK),
        .rst_n(NRST),
        .active(active),
        .sample(SAMPLE_IN),
        .estimate(estimate),
        .sample_out(SAMPLE_OUT)
    );

    assign HIGH_FREQ_MODE = hf_r;
    // only the full code enables it; 00, 01, 10 stay disabled
    assign LOW_SPEED_MODE = (speed_r == LOW_SPEED_CODE);
    assign CORR_ACTIVE = active;

endmodule
`default_nettype wire

// ==== offset_corr_pkg.sv ====
// shared constants, field layout and carrier types of the offset correction block
// assumes one sample clock; register indices are word indices on AXI4-Lite
package offset_corr_pkg;

    // widths
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam int SAMPLE_W = 12;
    localparam int ERR_W = 14;
    localparam int ACC_W = 46;
    localparam int IDX_W = 8;
    localparam int IDX_LSB = 2;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FORMAT_CTRL = 8'h3D;
    localparam logic [IDX_W-1:0] IDX_DIGITAL_MODE = 8'h42;
    localparam logic [IDX_W-1:0] IDX_LOOP_CTRL = 8'hCF;
    localparam logic [IDX_W-1:0] IDX_HF_TUNING = 8'hD8;
    localparam logic [IDX_W-1:0] IDX_TARGET_SHIFT = 8'hD9;
    localparam logic [IDX_W-1:0] IDX_SPEED_SEL = 8'hDF;
    localparam logic [IDX_W-1:0] IDX_EST_STATUS = 8'hE0;

    // field positions
    localparam int FMT_EN_BIT = 5;
    localparam int DIG_EN_BIT = 3;
    localparam int HF_BIT = 0;
    localparam int PED_LSB = 4;
    localparam int PED_MSB = 7;
    localparam int HOLD_BIT = 7;
    localparam int SPAN_LSB = 2;
    localparam int SPAN_MSB = 5;
    localparam int SPEED_LSB = 4;
    localparam int SPEED_MSB = 5;
    localparam int STAT_ACTIVE_BIT = 31;
    localparam int STAT_HOLD_BIT = 30;

    // reset values and codes
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] LOW_SPEED_CODE = 2'h3;
    localparam logic [SAMPLE_W-1:0] MID_CODE = 12'h800;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 12'hFFF;
    localparam logic [5:0] SPAN_BASE_SHIFT = 6'h14;
    localparam logic [3:0] SPAN_MAX_CODE = 4'hB;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic enable;
        logic hold;
        logic [3:0] span;
        logic signed [3:0] pedestal;
    } loop_cfg_t;

    // loop span code to averaging shift, 2^20 cycles at code 0, capped at code 11
    function automatic logic [5:0] span_shift(input logic [3:0] span);
        logic [3:0] c;
        c = (span > SPAN_MAX_CODE) ? SPAN_MAX_CODE : span;
        span_shift = SPAN_BASE_SHIFT + {2'h0, c};
    endfunction

    // clamp a signed difference into the unsigned code range
    function automatic logic [SAMPLE_W-1:0] sat_code(input logic signed [ERR_W:0] v);
        if (v < 0) begin
            sat_code = '0;
        end else if (v > $signed({3'h0, SAMPLE_MAX})) begin
            sat_code = SAMPLE_MAX;
        end else begin
            sat_code = v[SAMPLE_W-1:0];
        end
    endfunction

endpackage

// ==== offset_estimator.sv ====
// first-order averaging estimate of the output offset against mid-code plus pedestal
// assumes samples arrive once per clock, offset binary
`timescale 1ns/10ps
`default_nettype none
module offset_estimator (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and samples
    input wire offset_corr_pkg::loop_cfg_t cfg,
    input wire logic [offset_corr_pkg::SAMPLE_W-1:0] sample,
    // estimate
    output logic signed [offset_corr_pkg::ERR_W-1:0] estimate
);
    import offset_corr_pkg::*;

    logic signed [ACC_W-1:0] acc_r;
    logic signed [ACC_W-1:0] acc_nxt;
    logic signed [ERR_W-1:0] est_r;
    logic signed [ERR_W-1:0] est_nxt;
    logic signed [ERR_W-1:0] target;
    logic signed [ERR_W-1:0] err;
    logic signed [ACC_W-1:0] decay;
    logic [5:0] sh;

    always_comb begin
        sh = span_shift(cfg.span);
        // converged output is mid-code shifted by the signed pedestal
        target = $signed({2'h0, MID_CODE}) + ERR_W'(cfg.pedestal);
        err = $signed({2'h0, sample}) - target;
        decay = acc_r >>> sh;
        acc_nxt = acc_r;
        // hold freezes the accumulator; disabled loop also freezes it
        if (cfg.enable && !cfg.hold) begin
            acc_nxt = acc_r + ACC_W'(err) - decay;
        end
        est_nxt = ERR_W'(acc_nxt >>> sh);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= '0;
            est_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            est_r <= est_nxt;
        end
    end

    assign estimate = est_r;

endmodule
`default_nettype wire

// ==== sample_corrector.sv ====
// subtracts the offset estimate from each sample, or passes the sample untouched
// assumes estimate and sample are on the same clock
`timescale 1ns/10ps
`default_nettype none
module sample_corrector (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control and data
    input wire logic active,
    input wire logic [offset_corr_pkg::SAMPLE_W-1:0] sample,
    input wire logic signed [offset_corr_pkg::ERR_W-1:0] estimate,
    // corrected sample
    output logic [offset_corr_pkg::SAMPLE_W-1:0] sample_out
);
    import offset_corr_pkg::*;

    logic [SAMPLE_W-1:0] out_r;
    logic [SAMPLE_W-1:0] out_nxt;

    always_comb begin
        out_nxt = sample;
        if (active) begin
            // saturate rather than wrap at the code range ends
            out_nxt = sat_code($signed({3'h0, sample}) - (ERR_W+1)'(estimate));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign sample_out = out_r;

endmodule
`default_nettype wire

// ==== offset_corr_chk.sv ====
// concurrent checks on the ports of the offset correction top module
// assumes one clock domain on REF_CLK with NRST as async active-low reset
`timescale 1ns/10ps
`default_nettype none
module offset_corr_chk (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // register bus
    input wire logic [offset_corr_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [offset_corr_pkg::AXI_DATA_W-1:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_BVALID,
    // samples and modes
    input wire logic [offset_corr_pkg::SAMPLE_W-1:0] SAMPLE_IN,
    input wire logic [offset_corr_pkg::SAMPLE_W-1:0] SAMPLE_OUT,
    input wire logic HIGH_FREQ_MODE,
    input wire logic LOW_SPEED_MODE,
    input wire logic CORR_ACTIVE
);
    import offset_corr_pkg::*;
    logic [IDX_W-1:0] rd_idx_r;
    // index of the read in flight, to tie read data to the mode pins
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rd_idx_r <= '0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rd_idx_r <= S_AXI_ARADDR[IDX_LSB +: IDX_W];
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // mode pins only move at the edge that stores a write
    hf_store_a: assert property ($changed(HIGH_FREQ_MODE) |-> $rose(S_AXI_BVALID))
        else $error("high freq mode moved without a write");
    speed_store_a: assert property ($changed(LOW_SPEED_MODE) |-> $rose(S_AXI_BVALID))
        else $error("low speed mode moved without a write");
    active_store_a: assert property ($changed(CORR_ACTIVE) |-> $rose(S_AXI_BVALID))
        else $error("correction active moved without a write");
    // fresh read data, not racing a store, agrees with the pins; a reported hold implies active
    hf_read_a: assert property ($rose(S_AXI_RVALID) && !$rose(S_AXI_BVALID)
        && rd_idx_r == IDX_HF_TUNING |-> HIGH_FREQ_MODE == S_AXI_RDATA[HF_BIT])
        else $error("high freq pin differs from register");
    speed_read_a: assert property ($rose(S_AXI_RVALID) && !$rose(S_AXI_BVALID)
        && rd_idx_r == IDX_SPEED_SEL
        |-> LOW_SPEED_MODE == (S_AXI_RDATA[SPEED_MSB:SPEED_LSB] == LOW_SPEED_CODE))
        else $error("low speed pin differs from select code");
    active_read_a: assert property ($rose(S_AXI_RVALID) && !$rose(S_AXI_BVALID)
        && rd_idx_r == IDX_EST_STATUS |-> S_AXI_RDATA[STAT_ACTIVE_BIT] == CORR_ACTIVE)
        else $error("status active differs from pin");
    hold_flag_a: assert property ($rose(S_AXI_RVALID) && rd_idx_r == IDX_EST_STATUS
        && S_AXI_RDATA[STAT_HOLD_BIT] |-> S_AXI_RDATA[STAT_ACTIVE_BIT])
        else $error("hold reported without correction active");
    // depth two so a lagging estimate pipe is covered too
    bypass_path_a: assert property ($past(NRST) && !CORR_ACTIVE && !$past(CORR_ACTIVE)
        && !$past(CORR_ACTIVE, 2) |-> SAMPLE_OUT == $past(SAMPLE_IN))
        else $error("bypassed sample not passed through");
endmodule
bind offset_corr_top offset_corr_chk chk (.REF_CLK, .NRST, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_BVALID, .SAMPLE_IN, .SAMPLE_OUT,
    .HIGH_FREQ_MODE, .LOW_SPEED_MODE, .CORR_ACTIVE);
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the offset correction top module
// assumes the package constants and a 100 MHz REF_CLK shared by bus and samples
`timescale 1ns/10ps
`default_nettype none
module tb;
    import offset_corr_pkg::*;
    logic REF_CLK, NRST;
    logic [AXI_ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [2:0] S_AXI_AWPROT, S_AXI_ARPROT;
    logic [AXI_DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [SAMPLE_W-1:0] SAMPLE_IN, SAMPLE_OUT, s_const, s_exp;
    logic HIGH_FREQ_MODE, LOW_SPEED_MODE, CORR_ACTIVE, p1, p2;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [SAMPLE_W-1:0] smp_q[$];
    logic [31:0] s_rnd, v;
    int smode, fail_count, checks_done, cyc, k;
    logic [7:0] tbl_idx [6] = '{IDX_LOOP_CTRL, IDX_HF_TUNING, IDX_TARGET_SHIFT, IDX_SPEED_SEL,
        IDX_FORMAT_CTRL, IDX_DIGITAL_MODE};
    logic [7:0] tbl_msk [4] = '{8'hBC, 8'h01, 8'hF0, 8'h30};

    offset_corr_top uut (.REF_CLK, .NRST, .S_AXI_AWADDR, .S_AXI_AWPROT, .S_AXI_AWVALID,
        .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
        .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARPROT,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY, .SAMPLE_IN, .SAMPLE_OUT, .HIGH_FREQ_MODE, .LOW_SPEED_MODE, .CORR_ACTIVE);

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    task automatic fail(input string m);
        $display("FAIL %0t %s", $time, m);
        fail_count++;
    endtask

    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok) fail(m);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // idle edge first, so strobes never toggle twice in one step
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r);
        @(posedge REF_CLK);
        wr_q.push_back(r);
        S_AXI_AWADDR <= {2'h0, i, 2'h0};
        S_AXI_WDATA <= {24'h0, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        // wait for BVALID; only the bench timeout ends a hung wait
        do begin
            @(posedge REF_CLK);
            if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r);
        @(posedge REF_CLK);
        rd_q.push_back({r, d});
        S_AXI_ARADDR <= {2'h0, i, 2'h0};
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge REF_CLK);
            if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
    endtask

    // sample driver: mode 1 expects pass-through, 2 a fixed value, 3 no check
    always @(posedge REF_CLK) begin
        s_rnd = $urandom;
        SAMPLE_IN <= (smode >= 2) ? s_const : s_rnd[11:0];
        if (smode == 1) smp_q.push_back(s_rnd[11:0]);
        if (smode == 2) smp_q.push_back(s_exp);
        p1 <= (smode == 1 || smode == 2);
        p2 <= p1;
    end

    // result watcher, oldest note first
    always @(posedge REF_CLK) begin
        if (S_AXI_BVALID === 1'b1 && S_AXI_BREADY === 1'b1) begin
            checks_done++;
            if (wr_q.size() == 0 || S_AXI_BRESP !== wr_q.pop_front()) fail("write response");
        end
        if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY === 1'b1) begin
            checks_done++;
            if (rd_q.size() == 0 || {S_AXI_RRESP, S_AXI_RDATA} !== rd_q.pop_front()) begin
                fail("read data");
            end
        end
        if (p2 === 1'b1) begin
            checks_done++;
            if (smp_q.size() == 0 || SAMPLE_OUT !== smp_q.pop_front()) fail("sample out");
        end
    end

    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            fail("timeout");
            results();
        end
    end

    initial begin
        NRST = 1'b0;
        {S_AXI_AWADDR, S_AXI_AWPROT, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID} = '0;
        {S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARPROT, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        S_AXI_WSTRB = 4'hF;
        {s_const, s_exp} = '0;
        {smode, fail_count, checks_done} = '0;
        v = $urandom(32'hB2BB);
        repeat (12) @(posedge REF_CLK);
        NRST <= 1'b1;
        smode = 1;
        for (k = 0; k < 6; k++) rd(tbl_idx[k], 32'h0, RESP_OKAY);
        chk(HIGH_FREQ_MODE === 1'b0 && LOW_SPEED_MODE === 1'b0, "reset modes");
        for (k = 0; k < 4; k++) begin
            v = $urandom & tbl_msk[k];
            wr(tbl_idx[k], v[7:0], RESP_OKAY);
            rd(tbl_idx[k], {24'h0, v[7:0]}, RESP_OKAY);
        end
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(IDX_EST_STATUS, 8'h55, RESP_SLVERR);
        for (k = 0; k < 4; k++) begin
            wr(IDX_SPEED_SEL, {2'h0, k[1:0], 4'h0}, RESP_OKAY);
            chk(LOW_SPEED_MODE === (k == 3), "low speed mode");
        end
        wr(IDX_HF_TUNING, 8'h01, RESP_OKAY);
        chk(HIGH_FREQ_MODE === 1'b1, "high freq set");
        wr(IDX_HF_TUNING, 8'h00, RESP_OKAY);
        chk(HIGH_FREQ_MODE === 1'b0, "high freq clear");
        // lane 0 strobe low: answered OKAY but nothing stored
        S_AXI_WSTRB <= 4'hE;
        wr(IDX_HF_TUNING, 8'h01, RESP_OKAY);
        chk(HIGH_FREQ_MODE === 1'b0, "masked lane stored");
        S_AXI_WSTRB <= 4'hF;
        // enable alone is not enough while low latency stays on
        wr(IDX_FORMAT_CTRL, 8'h20, RESP_OKAY);
        chk(CORR_ACTIVE === 1'b0, "low latency bypass");
        repeat (20) @(posedge REF_CLK);
        wr(IDX_FORMAT_CTRL, 8'h00, RESP_OKAY);
        wr(IDX_DIGITAL_MODE, 8'h08, RESP_OKAY);
        chk(CORR_ACTIVE === 1'b0, "correction disabled");
        repeat (20) @(posedge REF_CLK);
        // sample sits on mid-code minus 8: no error, estimate stays 0
        s_const = 12'h7F8;
        s_exp = 12'h7F8;
        smode = 2;
        wr(IDX_LOOP_CTRL, 8'h00, RESP_OKAY);
        wr(IDX_TARGET_SHIFT, 8'h80, RESP_OKAY);
        wr(IDX_FORMAT_CTRL, 8'h20, RESP_OKAY);
        chk(CORR_ACTIVE === 1'b1, "correction active");
        repeat (600) @(posedge REF_CLK);
        rd(IDX_EST_STATUS, 32'h8000_0000, RESP_OKAY);
        // large error grows the estimate to 2 within about 1300 cycles
        smode = 3;
        s_const = 12'hFF8;
        wr(IDX_TARGET_SHIFT, 8'h70, RESP_OKAY);
        repeat (1300) @(posedge REF_CLK);
        wr(IDX_LOOP_CTRL, 8'h80, RESP_OKAY);
        rd(IDX_EST_STATUS, 32'hC000_0002, RESP_OKAY);
        s_exp = 12'hFF6;
        smode = 2;
        repeat (400) @(posedge REF_CLK);
        rd(IDX_EST_STATUS, 32'hC000_0002, RESP_OKAY);
        smode = 3;
        wr(IDX_LOOP_CTRL, 8'h84, RESP_OKAY);
        rd(IDX_EST_STATUS, 32'hC000_0001, RESP_OKAY);
        wr(IDX_FORMAT_CTRL, 8'h00, RESP_OKAY);
        // disabled loop keeps its estimate and reports no hold
        rd(IDX_EST_STATUS, 32'h0000_0001, RESP_OKAY);
        smode = 1;
        repeat (10) @(posedge REF_CLK);
        results();
    end
endmodule
`default_nettype wire
